// ==== include/tlic_pkg.sv ====
// Constants and types shared by the two-level interrupt controller
package tlic_pkg;

	// ==========================================================
	// Sources and polling order (index 0 polled first)
	localparam int unsigned NUM_SRC      = 6;
	localparam int unsigned SRC_IDX_W    = 3;
	localparam int unsigned SRC_EXT_ZERO = 0;
	localparam int unsigned SRC_TMR_ZERO = 1;
	localparam int unsigned SRC_EXT_ONE  = 2;
	localparam int unsigned SRC_TMR_ONE  = 3;
	localparam int unsigned SRC_SERIAL   = 4;
	localparam int unsigned SRC_TMR_TWO  = 5;
	// Third timer present in this variant
	localparam logic        HAS_TMR_TWO  = 1'b1;

	// ==========================================================
	// Enable mask fields
	localparam int unsigned IE_GLOBAL_BIT = 7;
	localparam logic [7:0]  IE_RESET      = 8'h00;
	localparam logic [7:0]  IP_RESET      = 8'h00;
	// Bit 6 reserved in both masks
	localparam logic [7:0]  MASK_WR_BITS  = 8'hBF;
	localparam logic [7:0]  PRIO_WR_BITS  = 8'h3F;

	// ==========================================================
	// Register byte offsets on the bus
	localparam logic [7:0] OFF_IE        = 8'h00;
	localparam logic [7:0] OFF_IP        = 8'h04;
	localparam logic [7:0] OFF_EVT_STAT  = 8'h08;
	localparam logic [7:0] OFF_EVT_CLR   = 8'h0C;
	localparam logic [7:0] OFF_EVT_EN    = 8'h10;
	localparam logic [7:0] OFF_STATE     = 8'h14;

	// ==========================================================
	// Event status bits
	localparam int unsigned EVT_W         = 3;
	localparam int unsigned EVT_CALL_LO   = 0;
	localparam int unsigned EVT_CALL_HI   = 1;
	localparam int unsigned EVT_BARE_RET  = 2;

	// ==========================================================
	// Vectors: base plus index times eight
	localparam logic [15:0] VEC_BASE      = 16'h0003;
	localparam int unsigned VEC_SHIFT     = 3;

	// ==========================================================
	// Machine cycle timing
	localparam int unsigned CLK_HZ        = 25_000_000;
	localparam int unsigned STATES_PER_MC = 6;
	localparam int unsigned CLKS_PER_STATE = 2;
	localparam logic [2:0]  SAMPLE_STATE  = 3'h5;
	localparam logic [2:0]  POLL_STATE    = 3'h1;

	// Call sequencer, Gray coded along the path
	typedef enum logic [1:0] {
		TLIC_WAIT = 2'b00,
		TLIC_POLL = 2'b01,
		TLIC_CALL = 2'b11
	} tlic_seq_e;

endpackage

// ==== rtl/tlic_resolver.sv ====
// Picks the winning interrupt source by level then polling order
`timescale 1ns/10ps
module tlic_resolver (
	input  wire logic [tlic_pkg::NUM_SRC-1:0]   req_hi,
	input  wire logic [tlic_pkg::NUM_SRC-1:0]   req_lo,
	output logic                                win_valid,
	output logic                                win_high,
	output logic [tlic_pkg::SRC_IDX_W-1:0]      win_idx
);
	import tlic_pkg::*;

	// ==========================================================
	// First-set chains, one stage per source
	logic [NUM_SRC:0]   seen_hi;   // Higher-order source already won
	logic [NUM_SRC:0]   seen_lo;
	logic [NUM_SRC-1:0] pick_hi;   // One-hot winner per level
	logic [NUM_SRC-1:0] pick_lo;

	assign seen_hi[0] = 1'b0;
	assign seen_lo[0] = 1'b0;

	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_chain
			// Lower index is polled first
			assign pick_hi[g]   = req_hi[g] & ~seen_hi[g];
			assign pick_lo[g]   = req_lo[g] & ~seen_lo[g];
			assign seen_hi[g+1] = seen_hi[g] | req_hi[g];
			assign seen_lo[g+1] = seen_lo[g] | req_lo[g];
		end
	endgenerate

	// ==========================================================
	// Encode the one-hot pick; high level beats low
	logic [SRC_IDX_W-1:0] idx_hi;
	logic [SRC_IDX_W-1:0] idx_lo;

	// Encoders for the two one-hot vectors
	always_comb begin
		idx_hi = '0;
		idx_lo = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (pick_hi[i]) begin
				idx_hi = SRC_IDX_W'(i);
			end
			if (pick_lo[i]) begin
				idx_lo = SRC_IDX_W'(i);
			end
		end
	end

	assign win_high  = seen_hi[NUM_SRC];
	assign win_valid = seen_hi[NUM_SRC] | seen_lo[NUM_SRC];
	assign win_idx   = win_high ? idx_hi : idx_lo;

endmodule

// ==== rtl/tlic_top.sv ====
// Two-level interrupt controller with APB registers and call sequencer
//
// Notes on behaviour
// [RULE1] Five sources, sixth for the third timer
// [RULE2] Per-source enable bit gates each request
// [RULE3] Global enable in top bit gates all
// [RULE4] Enable mask layout fixed, bit 6 reserved
// [RULE5] Cleared enable bit blocks that source's service
// [RULE6] Per-source priority bit selects one of two
// [RULE7] High preempts low; low never preempts low
// [RULE8] High in progress blocks every other request
// [RULE9] Level first, then fixed polling order
// [RULE10] Sample in state 5, poll next cycle
// [RULE11] Call saves only the program counter
// [RULE12] In-progress flag per level, return clears it
`timescale 1ns/10ps
module tlic_top (
	input  wire logic                            clock,
	input  wire logic                            rst,
	// APB slave
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [7:0]                      paddr,
	input  wire logic [31:0]                     pwdata,
	output logic [31:0]                          prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	// External request pins, asynchronous
	input  wire logic                            ext_zero_req,
	input  wire logic                            ext_one_req,
	// On-chip request flags, same clock
	input  wire logic                            tmr_zero_req,
	input  wire logic                            tmr_one_req,
	input  wire logic                            serial_req,
	input  wire logic                            tmr_two_req,
	// Core sequencer handshake
	output logic                                 call_req,
	output logic [15:0]                          call_vector,
	output logic                                 call_push_pc_only,
	input  wire logic                            call_ack,
	input  wire logic                            return_from_interrupt,
	// Machine state and interrupt out
	output logic [2:0]                           mc_state,
	output logic                                 irq
);
	import tlic_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic [1:0] ext_meta_r;   // First stage, read only by second
	logic [1:0] ext_sync_r;   // Safe to use

	// Two flops per external pin
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ext_meta_r <= 2'h0;
			ext_sync_r <= 2'h0;
		end else begin
			ext_meta_r <= {ext_one_req, ext_zero_req};
			ext_sync_r <= ext_meta_r;
		end
	end

	// [RULE1] Source vector assembly
	logic [NUM_SRC-1:0] src_flags;
	assign src_flags[SRC_EXT_ZERO] = ext_sync_r[0];
	assign src_flags[SRC_TMR_ZERO] = tmr_zero_req;
	assign src_flags[SRC_EXT_ONE]  = ext_sync_r[1];
	assign src_flags[SRC_TMR_ONE]  = tmr_one_req;
	assign src_flags[SRC_SERIAL]   = serial_req;
	assign src_flags[SRC_TMR_TWO]  = tmr_two_req & HAS_TMR_TWO;

	// ==========================================================
	// Machine cycle timing
	localparam int unsigned DIV_W = 2;
	logic [DIV_W-1:0] div_r;       // Clocks within a state
	logic             state_tick;  // One-cycle enable per state
	logic [2:0]       mc_state_r;  // 1..6

	assign state_tick = (div_r == DIV_W'(CLKS_PER_STATE - 1));

	// Divider gives one enable pulse per state time
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_r <= '0;
		end else if (state_tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	// State counter wraps after the sixth state
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mc_state_r <= 3'h1;
		end else if (state_tick) begin
			if (mc_state_r == 3'(STATES_PER_MC)) begin
				mc_state_r <= 3'h1;
			end else begin
				mc_state_r <= mc_state_r + 3'h1;
			end
		end
	end

	assign mc_state = mc_state_r;

	// Last clock of the sample state and of state 6, before poll state 1
	logic sample_now;
	logic poll_now;
	assign sample_now = state_tick & (mc_state_r == SAMPLE_STATE);
	assign poll_now   = state_tick & (mc_state_r == 3'(STATES_PER_MC));

	// ==========================================================
	// Registers
	logic [7:0]         ie_r;      // Enable mask
	logic [7:0]         ip_r;      // Priority select mask
	logic [EVT_W-1:0]   evt_r;     // Sticky events
	logic [EVT_W-1:0]   evt_en_r;  // Event interrupt enables
	logic [NUM_SRC-1:0] sample_r;  // Flags latched at state 5
	logic               hip_r;     // High level in progress
	logic               lip_r;     // Low level in progress

	// APB decode
	logic setup_ph;
	logic access_ph;
	logic wr_go;
	logic hit_ie;
	logic hit_ip;
	logic hit_stat;
	logic hit_clr;
	logic hit_en;
	logic hit_state;
	logic mapped;

	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign wr_go     = access_ph & pwrite;
	assign hit_ie    = (paddr == OFF_IE);
	assign hit_ip    = (paddr == OFF_IP);
	assign hit_stat  = (paddr == OFF_EVT_STAT);
	assign hit_clr   = (paddr == OFF_EVT_CLR);
	assign hit_en    = (paddr == OFF_EVT_EN);
	assign hit_state = (paddr == OFF_STATE);
	assign mapped    = hit_ie | hit_ip | hit_stat | hit_clr
		| hit_en | hit_state;

	// Zero wait states; unmapped access flagged as error
	assign pready  = 1'b1;
	assign pslverr = access_ph & ~mapped;

	// Read mux, sampled into prdata during setup
	logic [31:0] rd_mux;
	assign rd_mux =
		hit_ie    ? {24'h0, ie_r} :
		hit_ip    ? {24'h0, ip_r} :
		hit_stat  ? {29'h0, evt_r} :
		hit_en    ? {29'h0, evt_en_r} :
		hit_state ? {18'h0, sample_r,
			1'b0, mc_state_r, 2'h0, hip_r, lip_r} :
		32'h0;

	// Read data comes from a flop, loaded in setup phase
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0;
		end else if (setup_ph && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// [RULE4] Reserved bit 6 stays zero
	// [RULE2] Software writes steer enables
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ie_r <= IE_RESET;
		end else if (wr_go && hit_ie) begin
			ie_r <= pwdata[7:0] & MASK_WR_BITS;
		end
	end

	// [RULE6] Priority bit per source
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ip_r <= IP_RESET;
		end else if (wr_go && hit_ip) begin
			ip_r <= pwdata[7:0] & PRIO_WR_BITS;
		end
	end

	// Event enables
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			evt_en_r <= '0;
		end else if (wr_go && hit_en) begin
			evt_en_r <= pwdata[EVT_W-1:0];
		end
	end

	// [RULE10] Latch every flag in state 5
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sample_r <= '0;
		end else if (sample_now) begin
			sample_r <= src_flags;
		end
	end

	// ==========================================================
	// Eligibility
	logic               glob_en;
	logic [NUM_SRC-1:0] cand;
	logic [NUM_SRC-1:0] prio;
	logic [NUM_SRC-1:0] elig_hi;
	logic [NUM_SRC-1:0] elig_lo;

	// [RULE3] Global enable gates all sources
	assign glob_en = ie_r[IE_GLOBAL_BIT];
	// [RULE5] Cleared per-source bit blocks service
	assign cand    = sample_r & ie_r[NUM_SRC-1:0] & {NUM_SRC{glob_en}};
	assign prio    = ip_r[NUM_SRC-1:0];
	// [RULE8] High in progress blocks everything
	// [RULE7] Low in progress blocks only low
	assign elig_hi = cand & prio & {NUM_SRC{~hip_r}};
	assign elig_lo = cand & ~prio & {NUM_SRC{~hip_r & ~lip_r}};

	logic                 win_valid;
	logic                 win_high;
	logic [SRC_IDX_W-1:0] win_idx;

	// [RULE9] Level first, then polling order
	tlic_resolver u_resolver (
		.req_hi    (elig_hi),
		.req_lo    (elig_lo),
		.win_valid (win_valid),
		.win_high  (win_high),
		.win_idx   (win_idx)
	);

	// ==========================================================
	// Call sequencer
	tlic_seq_e seq_r;
	tlic_seq_e seq_nxt;
	logic      call_high_r;    // Level of the pending call
	logic      take_call;

	assign take_call = (seq_r == TLIC_CALL) & call_ack;

	// Next state: wait for poll, decide, hold request until ack
	always_comb begin
		seq_nxt = seq_r;
		case (seq_r)
			TLIC_WAIT: begin
				if (poll_now) begin
					seq_nxt = TLIC_POLL;
				end
			end
			TLIC_POLL: begin
				// Poll once per machine cycle
				if (win_valid) begin
					seq_nxt = TLIC_CALL;
				end else begin
					seq_nxt = TLIC_WAIT;
				end
			end
			TLIC_CALL: begin
				if (call_ack) begin
					seq_nxt = TLIC_WAIT;
				end
			end
			default: begin
				seq_nxt = TLIC_WAIT;
			end
		endcase
	end

	// Sequencer state flop
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			seq_r <= TLIC_WAIT;
		end else begin
			seq_r <= seq_nxt;
		end
	end

	// [RULE10] Vector fixed per source
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			call_vector <= 16'h0000;
			call_high_r <= 1'b0;
		end else if (seq_r == TLIC_POLL && win_valid) begin
			call_vector <= VEC_BASE
				+ {10'h0, win_idx, 3'h0};
			call_high_r <= win_high;
		end
	end

	assign call_req = (seq_r == TLIC_CALL);
	// [RULE11] Core pushes only the PC
	assign call_push_pc_only = 1'b1;

	// ==========================================================
	// In-progress flags
	logic ret_hi;
	logic ret_lo;
	logic ret_bare;

	// Return ends the highest active level
	assign ret_hi   = return_from_interrupt & hip_r;
	assign ret_lo   = return_from_interrupt & ~hip_r & lip_r;
	assign ret_bare = return_from_interrupt & ~hip_r & ~lip_r;

	// [RULE12] Set on call, cleared by return
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hip_r <= 1'b0;
			lip_r <= 1'b0;
		end else begin
			if (take_call && call_high_r) begin
				hip_r <= 1'b1;
			end else if (ret_hi) begin
				hip_r <= 1'b0;
			end
			if (take_call && !call_high_r) begin
				lip_r <= 1'b1;
			end else if (ret_lo) begin
				lip_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Event status and interrupt output
	logic [EVT_W-1:0] evt_set;
	logic [EVT_W-1:0] evt_clr;

	assign evt_set[EVT_CALL_LO]  = take_call & ~call_high_r;
	assign evt_set[EVT_CALL_HI]  = take_call & call_high_r;
	assign evt_set[EVT_BARE_RET] = ret_bare;
	assign evt_clr = (wr_go && hit_clr) ? pwdata[EVT_W-1:0] : '0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			evt_r <= '0;
		end else begin
			evt_r <= (evt_r & ~evt_clr) | evt_set;
		end
	end

	assign irq = |(evt_r & evt_en_r);

endmodule

// ==== tb/tlic_sva.sv ====
// Port checker for the two-level interrupt controller
`timescale 1ns/10ps
module tlic_sva (
	input wire logic	clock,
	input wire logic	rst,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [7:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic	pslverr,
	input wire logic	call_req,
	input wire logic [15:0]	call_vector,
	input wire logic	call_push_pc_only,
	input wire logic	call_ack,
	input wire logic	return_from_interrupt,
	input wire logic [2:0]	mc_state
);
	import tlic_pkg::*;
	// ==========
	// Shadow masks and in-progress flags
	logic [7:0]	ie_r;
	logic [7:0]	ip_r;
	logic		lo_ip_r;
	logic		hi_ip_r;
	// Source index and level of the pending call
	wire logic [15:0]	vec_off = call_vector - VEC_BASE;
	wire logic [2:0]	vec_idx = vec_off[5:3];
	wire logic		vec_hi = ip_r[vec_idx];
	wire logic		wr_hit = psel && penable && pwrite;
	// Mirror writes; bench never acks and returns together
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ie_r <= IE_RESET;
			ip_r <= IP_RESET;
			lo_ip_r <= 1'b0;
			hi_ip_r <= 1'b0;
		end else begin
			if (wr_hit && paddr == OFF_IE) begin
				ie_r <= pwdata[7:0];
			end
			if (wr_hit && paddr == OFF_IP) begin
				ip_r <= pwdata[7:0];
			end
			if (call_req && call_ack && vec_hi) begin
				hi_ip_r <= 1'b1;
			end else if (call_req && call_ack) begin
				lo_ip_r <= 1'b1;
			end else if (return_from_interrupt && hi_ip_r) begin
				hi_ip_r <= 1'b0;
			end else if (return_from_interrupt) begin
				lo_ip_r <= 1'b0;
			end
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_pc_only: assert property (call_push_pc_only)
		else $error("call saves more than the PC");
	a_call_hold: assert property (call_req && !call_ack |=>
		call_req && $stable(call_vector)) else $error("call dropped early");
	a_call_drop: assert property (call_req && call_ack |=>
		!call_req) else $error("call held after ack");
	a_vec_form: assert property (call_req |-> vec_idx < 3'h6
		&& vec_off[2:0] == 3'h0) else $error("bad vector");
	a_global_gate: assert property ($rose(call_req) |->
		ie_r[IE_GLOBAL_BIT]) else $error("call with global off");
	a_src_gate: assert property ($rose(call_req) |->
		ie_r[vec_idx]) else $error("call from disabled source");
	a_high_block: assert property ($rose(call_req) |->
		!hi_ip_r) else $error("call during high service");
	a_low_nest: assert property ($rose(call_req) && lo_ip_r |->
		vec_hi) else $error("low nested in low");
	a_state_step: assert property ($changed(mc_state) |->
		mc_state == ($past(mc_state) == 3'h6 ? 3'h1 : $past(mc_state) + 3'h1))
		else $error("machine state out of order");
	a_state_len: assert property ($changed(mc_state) |=>
		$stable(mc_state)) else $error("state shorter than two clocks");
	a_bad_addr: assert property (psel && penable && paddr > OFF_STATE
		|-> pslverr) else $error("unmapped access not refused");
endmodule

// ==== tb/tlic_core_model.sv ====
// Core sequencer model: takes calls, issues returns
`timescale 1ns/10ps
module tlic_core_model (
	input wire logic	clock,
	input wire logic	rst,
	input wire logic	call_req,
	input wire logic [15:0]	call_vector,
	input wire logic [1:0]	ack_dly,
	input wire logic	ret_go,
	output logic		call_ack,
	output logic		return_from_interrupt,
	output logic [7:0]	taken_cnt,
	output logic [15:0]	taken_vec
);
	logic [1:0]	wait_r;
	// Ack after ack_dly clocks, prompt or slow
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			call_ack <= 1'b0;
			return_from_interrupt <= 1'b0;
			wait_r <= 2'h0;
			taken_cnt <= 8'h00;
			taken_vec <= 16'h0000;
		end else begin
			return_from_interrupt <= ret_go;
			call_ack <= 1'b0;
			if (call_req && !call_ack && wait_r == ack_dly) begin
				call_ack <= 1'b1;
				wait_r <= 2'h0;
				taken_cnt <= taken_cnt + 8'h01;
				taken_vec <= call_vector;
			end else if (call_req && !call_ack) begin
				wait_r <= wait_r + 2'h1;
			end
		end
	end
endmodule

// ==== tb/tlic_top_tb.sv ====
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/10ps
module tlic_top_tb;
	import tlic_pkg::*;
	logic		clock, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]	paddr, taken_cnt;
	logic [31:0]	pwdata, prdata, rd, lf;
	logic [5:0]	req;
	logic		call_req, call_ack, push_pc, ret_pulse, irq, ret_go;
	logic [15:0]	call_vector, taken_vec;
	logic [1:0]	ack_dly;
	int		error_cnt, check_count, w;
	// ==========
	// Clock, design and core model
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	tlic_top dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_zero_req(req[0]),
		.tmr_zero_req(req[1]), .ext_one_req(req[2]), .tmr_one_req(req[3]),
		.serial_req(req[4]), .tmr_two_req(req[5]), .call_req(call_req),
		.call_vector(call_vector), .call_push_pc_only(push_pc),
		.call_ack(call_ack), .return_from_interrupt(ret_pulse),
		.mc_state(), .irq(irq));
	tlic_core_model core (.clock(clock), .rst(rst), .call_req(call_req),
		.call_vector(call_vector), .ack_dly(ack_dly), .ret_go(ret_go),
		.call_ack(call_ack), .return_from_interrupt(ret_pulse),
		.taken_cnt(taken_cnt), .taken_vec(taken_vec));
	// ==========
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Winner: high level first, then lowest index
	function automatic int win(input logic [5:0] r, input logic [5:0] p);
		for (int i = 0; i < 6; i++) if (r[i] && p[i]) return i;
		for (int i = 0; i < 6; i++) if (r[i]) return i;
		return 0;
	endfunction
	task automatic end_sim();
		if (error_cnt == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// APB cycle; rd holds read data, an idle cycle follows
	task automatic apb(input logic [7:0] a, input logic wr, logic [31:0] d);
		int n;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = pslverr ? 32'hEEEEEEEE : prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
		if (n >= 20) begin
			chk("apb_wait", 0, 1);
			end_sim();
		end
	endtask
	// Wait for a taken call, check its vector, drop that request
	task automatic take(input int idx);
		logic [7:0] c;
		int n;
		c = taken_cnt;
		n = 0;
		while (taken_cnt === c && n < 80) begin
			@(posedge clock);
			n++;
		end
		if (n >= 80) begin
			chk("call_wait", 0, 1);
			end_sim();
		end
		chk("vector", VEC_BASE + (idx << VEC_SHIFT), {16'h0, taken_vec});
		req[idx] <= 1'b0;
		@(posedge clock);
	endtask
	// Longer than sync, sample and poll together
	task automatic none();
		logic [7:0] c;
		c = taken_cnt;
		repeat (40) @(posedge clock);
		chk("no_call", {24'h0, c}, {24'h0, taken_cnt});
	endtask
	task automatic ret();
		ret_go <= 1'b1;
		@(posedge clock);
		ret_go <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	// ==========
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, req, ret_go} = '0;
		{ack_dly, error_cnt, check_count} = '0;
		rst = 1'b1;
		lf = 32'h6886;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		apb(OFF_IE, 0, 0);
		chk("ie_reset", {24'h0, IE_RESET}, rd);
		apb(OFF_IE, 1, 32'hFF);
		apb(OFF_IE, 0, 0);
		chk("ie_bits", 32'hBF, rd);
		apb(OFF_IP, 1, 32'hFF);
		apb(OFF_IP, 0, 0);
		chk("ip_bits", 32'h3F, rd);
		apb(8'h40, 0, 0);
		chk("unmapped", 32'hEEEEEEEE, rd);
		apb(OFF_IP, 1, 0);
		// One source enabled, all requesting
		for (int i = 0; i < 6; i++) begin
			apb(OFF_IE, 1, 32'h80 | (32'h1 << i));
			req <= 6'h3F;
			take(i);
			// Let the sampled flag of source i clear before the return
			repeat (16) @(posedge clock);
			ret();
			none();
			req <= 6'h00;
		end
		// Random levels and request sets
		for (int k = 0; k < 10; k++) begin
			lf = lfsr(lf);
			ack_dly <= lf[9:8];
			apb(OFF_IP, 1, {26'h0, lf[5:0]});
			apb(OFF_IE, 1, 32'h3F);
			req <= lf[13:8] | 6'h01 << lf[17:16];
			none();
			w = win(lf[13:8] | 6'h01 << lf[17:16], lf[5:0]);
			apb(OFF_IE, 1, 32'hBF);
			take(w);
			none();
			req <= 6'h00;
			repeat (16) @(posedge clock);
			ret();
		end
		// Nesting: 0 low, 1 and 2 high, 3 low
		apb(OFF_EVT_CLR, 1, 32'h7);
		apb(OFF_EVT_EN, 1, 32'h3);
		apb(OFF_IP, 1, 32'h06);
		req <= 6'h01;
		take(0);
		apb(OFF_STATE, 0, 0);
		chk("low_busy", 32'h1, rd & 32'h3);
		req <= 6'h08;
		none();
		apb(OFF_STATE, 0, 0);
		chk("sampled", 32'h0801, rd & 32'h3F03);
		req <= 6'h0A;
		take(1);
		req <= 6'h0C;
		none();
		ret();
		take(2);
		repeat (16) @(posedge clock);
		ret();
		none();
		ret();
		take(3);
		ret();
		apb(OFF_EVT_STAT, 0, 0);
		chk("evt_calls", 32'h3, rd);
		chk("irq_on", 1, {31'h0, irq});
		apb(OFF_EVT_CLR, 1, 32'h7);
		apb(OFF_EVT_EN, 1, 32'h4);
		ret();
		apb(OFF_EVT_STAT, 0, 0);
		chk("evt_bare", 32'h4, rd);
		apb(OFF_EVT_EN, 1, 32'h0);
		chk("irq_mask", 0, {31'h0, irq});
		apb(OFF_EVT_CLR, 1, 32'h7);
		apb(OFF_EVT_STAT, 0, 0);
		chk("evt_clr", 0, rd);
		end_sim();
	end
endmodule
bind tlic_top tlic_sva chk (.clock(clock), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pslverr(pslverr), .call_req(call_req), .call_vector(call_vector),
	.call_push_pc_only(call_push_pc_only), .call_ack(call_ack),
	.return_from_interrupt(return_from_interrupt), .mc_state(mc_state));
